// file: hdl/vmx_pkg.sv
// Shared constants, types and helper functions for the video matrix control block
`default_nettype none
package vmx_pkg;

  // Fixed upper nibble of the slave address byte (1,0,0,1)
  localparam logic [3:0] ADDR_FIXED    = 4'h9;
  // Strap code that selects the DC-controlled non-bus mode
  localparam logic [2:0] STRAP_NONBUS  = 3'h7;
  // Bit count that marks a complete received byte
  localparam logic [3:0] BIT_LAST      = 4'h8;

  // Register pointer values
  localparam logic [1:0] REG_ROUTING   = 2'h0;
  localparam logic [1:0] REG_GAIN      = 2'h1;
  localparam logic [1:0] REG_OE        = 2'h2;
  localparam logic [1:0] REG_LAST      = 2'h2;

  // Values after power-on reset
  localparam logic [7:0] RST_ROUTING   = 8'h00;
  localparam logic [7:0] RST_GAIN      = 8'h00;
  localparam logic [7:0] RST_OE        = 8'h00;

  // Field positions inside the gain/clamp/aux and output-enable registers
  localparam int GAIN_LSB  = 4;
  localparam int GAIN_MSB  = 7;
  localparam int CLAMP_LSB = 2;
  localparam int CLAMP_MSB = 3;
  localparam int AUX_LSB   = 0;
  localparam int AUX_MSB   = 1;
  localparam int OE_LSB    = 0;
  localparam int OE_MSB    = 3;

  // Output levels used in non-bus mode
  localparam logic [3:0] NB_DRIVE_ALL  = 4'hf;
  localparam logic [3:0] NB_GAIN_TWO   = 4'h0;
  localparam logic [1:0] NB_CLAMP_ON   = 2'h0;

  typedef enum logic [1:0] {LS_IDLE, LS_RECV, LS_ACK, LS_IGNORE} vmx_link_e;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} vmx_phase_e;

  // State of the bus-facing receiver
  typedef struct packed {
    vmx_link_e  st;
    vmx_phase_e phase;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [1:0] ptr;
    logic       scl_q;
    logic       sda_q;
    logic       sda_oe;
    logic       wr_pls;
    logic [9:0] wr_word;
  } vmx_link_s;

  // State of the register file and the output stage
  typedef struct packed {
    logic [7:0] routing;
    logic [7:0] gain;
    logic [7:0] oe;
    logic       bus_mode;
    logic [7:0] route_out;
    logic [3:0] gain_out;
    logic [1:0] clamp_out;
    logic [1:0] aux_out;
    logic [3:0] drive_out;
  } vmx_core_s;

  localparam vmx_link_s LINK_RST = '{st: LS_IDLE, phase: PH_ADDR, cnt: 4'h0, shreg: 8'h00,
                                     ptr: 2'h0, scl_q: 1'b1, sda_q: 1'b1, sda_oe: 1'b0,
                                     wr_pls: 1'b0, wr_word: 10'h000};

  localparam vmx_core_s CORE_RST = '{routing: RST_ROUTING, gain: RST_GAIN, oe: RST_OE,
                                     bus_mode: 1'b1, route_out: RST_ROUTING,
                                     gain_out: 4'h0, clamp_out: 2'h0, aux_out: 2'h0,
                                     drive_out: 4'h0};

  // Address byte match: fixed nibble, strap bits, write direction only
  function automatic logic addr_ok(input logic [7:0] b, input logic [2:0] strap);
    addr_ok = (b == {ADDR_FIXED, strap, 1'b0});
  endfunction : addr_ok

  // Pointer advance with roll-over after the last register
  function automatic logic [1:0] next_ptr(input logic [1:0] p);
    next_ptr = (p >= REG_LAST) ? REG_ROUTING : 2'(p + 2'h1);
  endfunction : next_ptr

  // Non-bus routing: output j takes input (code xor j)
  function automatic logic [7:0] nonbus_route(input logic [1:0] code);
    nonbus_route = {code ^ 2'h3, code ^ 2'h2, code ^ 2'h1, code};
  endfunction : nonbus_route

endpackage : vmx_pkg
`default_nettype wire

// file: hdl/vmx_sync.sv
// Two flip-flop level synchroniser, one bit per lane
`timescale 1ns/100ps
`default_nettype none
module vmx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vmx_sync_s;

  vmx_sync_s r_ff;
  vmx_sync_s nxt_r;

  // First stage feeds only the second stage
  always_comb begin
    nxt_r    = r_ff;
    nxt_r.s1 = d;
    nxt_r.s2 = r_ff.s1;
  end

  // Not gated by the clock enable, so levels stay fresh while frozen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign q = r_ff.s2;

endmodule : vmx_sync
`default_nettype wire

// file: hdl/vmx_xfer.sv
// Toggle handshake that carries one register write word between clock domains
`timescale 1ns/100ps
`default_nettype none
module vmx_xfer (
  input  wire logic       src_clk,
  input  wire logic       src_valid,
  input  wire logic [9:0] src_word,
  input  wire logic       dst_clk,
  input  wire logic       dst_ce,
  input  wire logic       rst,
  output logic            dst_valid,
  output logic      [9:0] dst_word
);

  typedef struct packed {
    logic       tgl;
    logic [9:0] word;
  } vmx_xsrc_s;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic       valid;
    logic [9:0] word;
  } vmx_xdst_s;

  vmx_xsrc_s s_ff;
  vmx_xsrc_s nxt_s;
  vmx_xdst_s d_ff;
  vmx_xdst_s nxt_d;

  // Word is held stable while the toggle crosses
  always_comb begin
    nxt_s = s_ff;
    if (src_valid) begin
      nxt_s.tgl  = ~s_ff.tgl;
      nxt_s.word = src_word;
    end
  end

  always_ff @(posedge src_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Toggle edge seen on the second and third stage only
  always_comb begin
    nxt_d       = d_ff;
    nxt_d.s1    = s_ff.tgl;
    nxt_d.s2    = d_ff.s1;
    // A pending word waits out a frozen enable instead of being lost
    if (dst_ce) begin
      nxt_d.valid = 1'b0;
      nxt_d.s3    = d_ff.s2;
      if (d_ff.s2 != d_ff.s3) begin
        nxt_d.valid = 1'b1;
        nxt_d.word  = s_ff.word;
      end
    end
  end

  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      d_ff <= '0;
    end else begin
      d_ff <= nxt_d;
    end
  end

  assign dst_valid = d_ff.valid;
  assign dst_word  = d_ff.word;

endmodule : vmx_xfer
`default_nettype wire

// file: hdl/vmx_ctrl.sv
// Top of the video matrix control block: two-wire write receiver and control registers
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Strap pins give low three address bits
// - All straps high: no bus, DC mode
// - Clock and data pins act as levels
// - Address byte 1001 plus straps, write only
// - Acknowledge address, pointer and every data byte
// - Pointers 0, 1, 2 select the three registers
// - Pointer increments after each data byte
// - Pointer wraps to first register after third
// - Routing register holds two bits per output
// - Source code selects input zero to three
// - Upper nibble holds per-output gain selects
// - Bits 3 and 2 control input clamping
// - Bits 1 and 0 set auxiliary outputs
// - Power-up: outputs high impedance, aux low
// - Gain bit 0 gives two, 1 one
// - Clamp bit 0 clamps, 1 mean biasing
// - Aux bit 0 low, 1 high
// - Enable bits 3:0 activate outputs, rest ignored
module vmx_ctrl (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] strap_in,
  output logic      [7:0] route_sel,
  output logic      [3:0] gain_one,
  output logic      [1:0] mean_bias,
  output logic      [1:0] aux_out,
  output logic      [3:0] drive_on,
  output logic            bus_mode
);

  vmx_pkg::vmx_link_s l_ff;
  vmx_pkg::vmx_link_s nxt_l;
  vmx_pkg::vmx_core_s c_ff;
  vmx_pkg::vmx_core_s nxt_c;

  logic [5:0] lsync;
  logic [4:0] rsync;
  logic       ce_l;
  logic       scl_l;
  logic       sda_l;
  logic [2:0] strap_l;
  logic       bus_l;
  logic       scl_r;
  logic       sda_r;
  logic [2:0] strap_r;
  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;
  logic       byte_end;
  logic       xv;
  logic [9:0] xword;

  // Pins and the enable into the link domain
  vmx_sync #(.W(6)) u_sync_link (
    .clk (link_clk),
    .rst (rst),
    .d   ({ce, scl_in, sda_in, strap_in}),
    .q   (lsync)
  );

  // Pins again into the register domain, for non-bus levels and mode
  vmx_sync #(.W(5)) u_sync_ref (
    .clk (ref_clk),
    .rst (rst),
    .d   ({scl_in, sda_in, strap_in}),
    .q   (rsync)
  );

  assign ce_l    = lsync[5];
  assign scl_l   = lsync[4];
  assign sda_l   = lsync[3];
  assign strap_l = lsync[2:0];
  assign scl_r   = rsync[4];
  assign sda_r   = rsync[3];
  assign strap_r = rsync[2:0];

  // All straps high takes the receiver off the bus
  assign bus_l = (strap_l != vmx_pkg::STRAP_NONBUS);

  // Bus conditions from the sampled lines; SCL must be slow against link_clk
  assign start_c  = scl_l & l_ff.scl_q & l_ff.sda_q & ~sda_l;
  assign stop_c   = scl_l & l_ff.scl_q & ~l_ff.sda_q & sda_l;
  assign rise_c   = scl_l & ~l_ff.scl_q;
  assign fall_c   = ~scl_l & l_ff.scl_q;
  assign byte_end = fall_c & (l_ff.cnt == vmx_pkg::BIT_LAST);

  // Receiver: shift on SCL rise, answer on SCL fall after the eighth bit
  always_comb begin
    nxt_l        = l_ff;
    nxt_l.wr_pls = 1'b0;
    if (ce_l) begin
      nxt_l.scl_q = scl_l;
      nxt_l.sda_q = sda_l;
      if (!bus_l) begin
        nxt_l.st     = vmx_pkg::LS_IDLE;
        nxt_l.sda_oe = 1'b0;
      end else if (start_c) begin
        // A repeated START also restarts the address phase
        nxt_l.st     = vmx_pkg::LS_RECV;
        nxt_l.phase  = vmx_pkg::PH_ADDR;
        nxt_l.cnt    = 4'h0;
        nxt_l.sda_oe = 1'b0;
      end else if (stop_c) begin
        nxt_l.st     = vmx_pkg::LS_IDLE;
        nxt_l.sda_oe = 1'b0;
      end else begin
        unique case (l_ff.st)
          vmx_pkg::LS_IDLE, vmx_pkg::LS_IGNORE: begin
            nxt_l.sda_oe = 1'b0;
          end
          vmx_pkg::LS_RECV: begin
            if (rise_c && l_ff.cnt != vmx_pkg::BIT_LAST) begin
              nxt_l.shreg = {l_ff.shreg[6:0], sda_l};
              nxt_l.cnt   = 4'(l_ff.cnt + 4'h1);
            end else if (byte_end) begin
              unique case (l_ff.phase)
                vmx_pkg::PH_ADDR: begin
                  if (vmx_pkg::addr_ok(l_ff.shreg, strap_l)) begin
                    nxt_l.st     = vmx_pkg::LS_ACK;
                    nxt_l.sda_oe = 1'b1;
                    nxt_l.phase  = vmx_pkg::PH_PTR;
                  end else begin
                    nxt_l.st = vmx_pkg::LS_IGNORE;
                  end
                end
                vmx_pkg::PH_PTR: begin
                  // Upper six bits are expected zero and are not looked at
                  nxt_l.ptr    = l_ff.shreg[1:0];
                  nxt_l.st     = vmx_pkg::LS_ACK;
                  nxt_l.sda_oe = 1'b1;
                  nxt_l.phase  = vmx_pkg::PH_DATA;
                end
                vmx_pkg::PH_DATA: begin
                  nxt_l.wr_pls  = 1'b1;
                  nxt_l.wr_word = {l_ff.ptr, l_ff.shreg};
                  nxt_l.ptr     = vmx_pkg::next_ptr(l_ff.ptr);
                  nxt_l.st      = vmx_pkg::LS_ACK;
                  nxt_l.sda_oe  = 1'b1;
                end
                default: begin
                  nxt_l.st = vmx_pkg::LS_IGNORE;
                end
              endcase
            end
          end
          vmx_pkg::LS_ACK: begin
            // Release on the fall that ends the acknowledge clock
            if (fall_c) begin
              nxt_l.st     = vmx_pkg::LS_RECV;
              nxt_l.cnt    = 4'h0;
              nxt_l.sda_oe = 1'b0;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      l_ff <= vmx_pkg::LINK_RST;
    end else begin
      l_ff <= nxt_l;
    end
  end

  // Open-drain data pin: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = l_ff.sda_oe;

  // Each accepted data byte crosses to the register domain as one word
  vmx_xfer u_xfer (
    .src_clk   (link_clk),
    .src_valid (l_ff.wr_pls),
    .src_word  (l_ff.wr_word),
    .dst_clk   (ref_clk),
    .dst_ce    (ce),
    .rst       (rst),
    .dst_valid (xv),
    .dst_word  (xword)
  );

  // Register file and registered output stage
  always_comb begin
    nxt_c = c_ff;
    if (ce) begin
      if (xv) begin
        unique case (xword[9:8])
          vmx_pkg::REG_ROUTING: nxt_c.routing = xword[7:0];
          vmx_pkg::REG_GAIN:    nxt_c.gain    = xword[7:0];
          vmx_pkg::REG_OE:      nxt_c.oe      = xword[7:0];
          default: begin
            // Pointer value 3 names no register; the byte is dropped
            nxt_c.routing = c_ff.routing;
          end
        endcase
      end
      nxt_c.bus_mode = (strap_r != vmx_pkg::STRAP_NONBUS);
      if (c_ff.bus_mode) begin
        // Codes pass straight to the switch: 00 is input 0 up to 11 input 3
        nxt_c.route_out = c_ff.routing;
        nxt_c.gain_out  = c_ff.gain[vmx_pkg::GAIN_MSB:vmx_pkg::GAIN_LSB];
        nxt_c.clamp_out = c_ff.gain[vmx_pkg::CLAMP_MSB:vmx_pkg::CLAMP_LSB];
        nxt_c.drive_out = c_ff.oe[vmx_pkg::OE_MSB:vmx_pkg::OE_LSB];
      end else begin
        // Lines are plain levels here; SCL swaps pairs, SDA swaps neighbours
        nxt_c.route_out = vmx_pkg::nonbus_route({scl_r, sda_r});
        nxt_c.gain_out  = vmx_pkg::NB_GAIN_TWO;
        nxt_c.clamp_out = vmx_pkg::NB_CLAMP_ON;
        nxt_c.drive_out = vmx_pkg::NB_DRIVE_ALL;
      end
      nxt_c.aux_out = c_ff.gain[vmx_pkg::AUX_MSB:vmx_pkg::AUX_LSB];
    end
  end

  // Reset values leave every output off and aux low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c_ff <= vmx_pkg::CORE_RST;
    end else begin
      c_ff <= nxt_c;
    end
  end

  assign route_sel = c_ff.route_out;
  assign gain_one  = c_ff.gain_out;
  assign mean_bias = c_ff.clamp_out;
  assign aux_out   = c_ff.aux_out;
  assign drive_on  = c_ff.drive_out;
  assign bus_mode  = c_ff.bus_mode;

  // Link-domain checks
  a_addr_reject: assert property (@(posedge link_clk) disable iff (rst)
    (ce_l && bus_l && !start_c && !stop_c && l_ff.st == vmx_pkg::LS_RECV &&
     l_ff.phase == vmx_pkg::PH_ADDR && byte_end && !vmx_pkg::addr_ok(l_ff.shreg, strap_l))
    |=> (l_ff.st == vmx_pkg::LS_IGNORE && !l_ff.sda_oe))
    else $error("address byte not rejected");

  a_ack_drive: assert property (@(posedge link_clk) disable iff (rst)
    (ce_l && bus_l && !start_c && !stop_c && l_ff.st == vmx_pkg::LS_RECV &&
     l_ff.phase != vmx_pkg::PH_ADDR && byte_end) |=> l_ff.sda_oe)
    else $error("byte not acknowledged");

  a_ptr_advance: assert property (@(posedge link_clk) disable iff (rst)
    l_ff.wr_pls |-> (l_ff.ptr == vmx_pkg::next_ptr(l_ff.wr_word[9:8])))
    else $error("pointer did not advance");

  a_oe_in_ack: assert property (@(posedge link_clk) disable iff (rst)
    l_ff.sda_oe |-> (l_ff.st == vmx_pkg::LS_ACK))
    else $error("data line driven outside acknowledge");

  // Register-domain checks
  a_route_write: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && xv && xword[9:8] == vmx_pkg::REG_ROUTING) |=> (c_ff.routing == $past(xword[7:0])))
    else $error("routing write lost");

  a_gain_write: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && xv && xword[9:8] == vmx_pkg::REG_GAIN) |=> ##1 (gain_one == $past(xword[7:4], 2)))
    else $error("gain write not at output");

  a_oe_follow: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && c_ff.bus_mode) |=> (drive_on == $past(c_ff.oe[3:0])))
    else $error("output enable mismatch");

  a_aux_follow: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> (aux_out == $past(c_ff.gain[1:0])))
    else $error("aux output mismatch");

  a_nonbus_out: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && !c_ff.bus_mode) |=> (drive_on == 4'hf && gain_one == 4'h0 &&
     route_sel == vmx_pkg::nonbus_route($past({scl_r, sda_r}))))
    else $error("non-bus outputs wrong");

endmodule : vmx_ctrl
`default_nettype wire

// file: verif/vmx_bus_master.sv
// Two-wire bus master model that drives the clock and pulls the data line
`timescale 1ns/100ps
`default_nettype none
module vmx_bus_master (
  input  wire logic ref_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_pull
);
  // Half SCL phase in ref clocks; kept above eight link clock periods
  localparam int H = 13;

  // Bus idles released; clock driven high, the pull-up holds data high
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic half();
    repeat (H) @(posedge ref_clk);
  endtask : half

  // Data falls while the clock is high
  task automatic start_c();
    sda_pull <= 1'b1;
    half();
    scl <= 1'b0;
  endtask : start_c

  // Data rises while the clock is high
  task automatic stop_c();
    repeat (3) @(posedge ref_clk);
    sda_pull <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_pull <= 1'b0;
    half();
  endtask : stop_c

  // Data changes a few cycles after the clock fall, never beside it, to avoid false framing
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      repeat (3) @(posedge ref_clk);
      sda_pull <= ~b[i];
      half();
      scl <= 1'b1;
      half();
      scl <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    sda_pull <= 1'b0;
    half();
    scl <= 1'b1;
    repeat (H / 2) @(posedge ref_clk);
    ack = ~sda_w;
    repeat (H - H / 2) @(posedge ref_clk);
    scl <= 1'b0;
  endtask : put_byte

  // Static levels for the non-bus mode
  task automatic set_lines(input logic c, input logic d);
    @(posedge ref_clk);
    scl      <= c;
    sda_pull <= ~d;
  endtask : set_lines
endmodule : vmx_bus_master
`default_nettype wire

// file: verif/video_matrix_i2c_control_test.sv
// Self-checking testbench for the video matrix control block
`timescale 1ns/100ps
`default_nettype none
module video_matrix_i2c_control_test;
  logic       ref_clk;
  logic       link_clk;
  logic       rst;
  logic       ce;
  logic [2:0] strap_in;
  logic       scl_w;
  logic       sda_pull;
  wire logic  sda_w;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] route_sel;
  logic [3:0] gain_one;
  logic [1:0] mean_bias;
  logic [1:0] aux_out;
  logic [3:0] drive_on;
  logic       bus_mode;
  int         err_total;
  int         n_compared;

  // Wired-AND data line with pull-up
  assign sda_w = (sda_pull | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;

  vmx_ctrl vmx_ctrl_i (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .link_clk (link_clk),
    .scl_in   (scl_w),
    .sda_in   (sda_w),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .strap_in (strap_in),
    .route_sel(route_sel),
    .gain_one (gain_one),
    .mean_bias(mean_bias),
    .aux_out  (aux_out),
    .drive_on (drive_on),
    .bus_mode (bus_mode)
  );

  vmx_bus_master vmx_bus_master_i (
    .ref_clk (ref_clk),
    .sda_w   (sda_w),
    .scl     (scl_w),
    .sda_pull(sda_pull)
  );

  // Clocks; link clock offset so the domains never line up
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  function automatic logic [7:0] adr(input logic [2:0] s, input logic rd);
    return {4'h9, s, rd};
  endfunction : adr

  // One transfer; a refused address ends it at once
  task automatic frame(input logic [7:0] b [6], input int n, input logic ack_exp);
    logic ack;
    vmx_bus_master_i.start_c();
    for (int i = 0; i < n; i++) begin
      vmx_bus_master_i.put_byte(b[i], ack);
      check("ack", {7'h00, ack}, {7'h00, ack_exp});
      if (!ack_exp) break;
    end
    vmx_bus_master_i.stop_c();
    // Crossing plus output pipeline settle well inside this
    repeat (10) @(posedge ref_clk);
  endtask : frame

  task automatic chk_outs(input logic [7:0] rs, input logic [3:0] g, input logic [1:0] m,
                          input logic [1:0] a, input logic [3:0] d);
    check("route_sel", route_sel, rs);
    check("gain_one", {4'h0, gain_one}, {4'h0, g});
    check("mean_bias", {6'h00, mean_bias}, {6'h00, m});
    check("aux_out", {6'h00, aux_out}, {6'h00, a});
    check("drive_on", {4'h0, drive_on}, {4'h0, d});
  endtask : chk_outs

  // Main sequence
  initial begin
    err_total  = 0;
    n_compared = 0;
    rst        = 1'b1;
    ce         = 1'b1;
    strap_in   = 3'h0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk_outs(8'h00, 4'h0, 2'h0, 2'h0, 4'h0);
    check("bus_mode", {7'h00, bus_mode}, 8'h01);
    // Every bus strap code answers at its own address, pointer upper bits zero
    for (int s = 0; s < 7; s++) begin
      strap_in <= 3'(s);
      repeat (10) @(posedge ref_clk);
      frame('{adr(3'(s), 1'b0), 8'h00, {2'h1, 3'(s), 3'(s)}, 8'h00, 8'h00, 8'h00}, 3, 1'b1);
      check("route_sel", route_sel, {2'h1, 3'(s), 3'(s)});
    end
    strap_in <= 3'h5;
    repeat (10) @(posedge ref_clk);
    // Four data bytes: fourth wraps and overwrites routing
    frame('{adr(3'h5, 1'b0), 8'h00, 8'h1B, 8'hA6, 8'h05, 8'hE4}, 6, 1'b1);
    chk_outs(8'hE4, 4'hA, 2'h1, 2'h2, 4'h5);
    // Start at pointer one; enable upper nibble must be ignored
    frame('{adr(3'h5, 1'b0), 8'h01, 8'h5F, 8'hF0, 8'h00, 8'h00}, 4, 1'b1);
    chk_outs(8'hE4, 4'h5, 2'h3, 2'h3, 4'h0);
    // Foreign strap address and read request are both left unanswered
    frame('{adr(3'h3, 1'b0), 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 3, 1'b0);
    frame('{adr(3'h5, 1'b1), 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 3, 1'b0);
    check("route_sel", route_sel, 8'hE4);
    // Pointer three names no register: byte dropped, next byte lands in routing
    frame('{adr(3'h5, 1'b0), 8'h03, 8'hFF, 8'h4E, 8'h00, 8'h00}, 4, 1'b1);
    chk_outs(8'h4E, 4'h5, 2'h3, 2'h3, 4'h0);
    // Enable low freezes the receiver: no answer, nothing written
    ce <= 1'b0;
    repeat (10) @(posedge ref_clk);
    frame('{adr(3'h5, 1'b0), 8'h00, 8'h1B, 8'h00, 8'h00, 8'h00}, 3, 1'b0);
    check("route_sel", route_sel, 8'h4E);
    ce <= 1'b1;
    repeat (10) @(posedge ref_clk);
    // All straps high: static levels steer the matrix
    strap_in <= 3'h7;
    repeat (10) @(posedge ref_clk);
    check("bus_mode", {7'h00, bus_mode}, 8'h00);
    chk_outs(8'h1B, 4'h0, 2'h0, 2'h3, 4'hF);
    vmx_bus_master_i.set_lines(1'b0, 1'b1);
    repeat (10) @(posedge ref_clk);
    check("route_sel", route_sel, 8'hB1);
    vmx_bus_master_i.set_lines(1'b1, 1'b1);
    repeat (10) @(posedge ref_clk);
    frame('{adr(3'h7, 1'b0), 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 3, 1'b0);
    stop_test();
  end

  // Watchdog: the sequence needs about 11300 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
endmodule : video_matrix_i2c_control_test
`default_nettype wire
